// >>> verilog/alarm_regs.svh
// Purpose: Constants for the alarm status and aggregation block
// Assumes: One clock, synchronous active-high reset
// Notes:   Counts, field widths and alarm bit positions; types live in alarm_pkg
`ifndef ALARM_REGS_SVH
`define ALARM_REGS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_REF 4
`define NUM_LOOP 4
`define NUM_GPIO 9
`define SEL_W 2
`define REF_ALM_W 3
`define LOOP_ALM_W 2
`define STATE_W 3

// ----------------------------------------
// Alarm bit positions
// ----------------------------------------
`define REF_FFO 0
`define REF_LOS 1
`define REF_ACT 2
`define LOOP_HOLD 0
`define LOOP_LOCK 1
`define SYS_LOOP 0

`endif

// >>> verilog/alarm_pkg.sv
// Purpose: Types for the alarm status and aggregation block
// Assumes: alarm_regs.svh included for widths
// Notes:   No constants beyond type shapes
`include "alarm_regs.svh"

package alarm_pkg;

  // Raw reference monitor indications
  typedef struct packed {
    logic freq_reject;
    logic freq_accept;
    logic period_over;
    logic act_over;
  } ref_mon_t;

  // Digital loop state machine states
  typedef enum logic [`STATE_W-1:0] {
    ST_FREERUN,
    ST_ACQUIRE,
    ST_LOCKED,
    ST_HOLDOVER,
    ST_OPEN
  } loop_state_t;

  // Individual pin function
  typedef enum logic [1:0] {
    PIN_OFF,
    PIN_LOS,
    PIN_LOL,
    PIN_HOLD
  } pin_mode_t;

  typedef struct packed {
    pin_mode_t mode;
    logic [`SEL_W-1:0] sel;
  } pin_cfg_t;

endpackage

// >>> verilog/alarm_status_aggregation.sv
// Purpose: Live/sticky alarm status, block stickies and pin aggregation
// Assumes: Inputs synchronous to clk_i; clear inputs are one-cycle pulses
// Notes:   Loop 0 is the system digital loop; all outputs registered
`include "alarm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module alarm_status_aggregation
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Alarm sources
  input wire alarm_pkg::ref_mon_t ref_mon_i [`NUM_REF],
  input wire alarm_pkg::loop_state_t loop_state_i [`NUM_LOOP],
  input wire logic apll_locked_i,
  // Control
  input wire logic global_en_set_i,
  input wire logic global_en_clr_i,
  input wire logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_alm_en_i,
  input wire logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_alm_en_i,
  input wire logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_alert_sel_i,
  input wire logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_alert_sel_i,
  input wire alarm_pkg::pin_cfg_t pin_cfg_i [`NUM_GPIO],
  input wire logic alert_pin_en_i,
  input wire logic [3:0] alert_pin_idx_i,
  // Sticky clear pulses
  input wire logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_clr_i,
  input wire logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_clr_i,
  input wire logic [`NUM_REF-1:0] ref_blk_clr_i,
  input wire logic [`NUM_LOOP-1:0] loop_blk_clr_i,
  // Status
  output logic global_en_o,
  output logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_live_o,
  output logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_sticky_o,
  output logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_live_o,
  output logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_sticky_o,
  output logic [`NUM_REF-1:0] ref_blk_o,
  output logic [`NUM_LOOP-1:0] loop_blk_o,
  output alarm_pkg::loop_state_t loop_state_o [`NUM_LOOP],
  // Pins
  output logic [`NUM_GPIO-1:0] gpio_o,
  output logic [`NUM_GPIO-1:0] gpio_oe_n_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Set dominates clear so a transition in the clear cycle is kept
  function automatic logic set_wins(input logic q, input logic set, input logic clr);
    set_wins = set | (q & ~clr);
  endfunction

  // ----------------------------------------
  // Global enable
  // ----------------------------------------
  logic global_en_q;
  logic global_en_d;

  assign global_en_d = global_en_set_i | (global_en_q & ~global_en_clr_i);

  // Enable register, off after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      global_en_q <= 1'b0;
    else
      global_en_q <= global_en_d;
  end

  // ----------------------------------------
  // Reference monitor alarms
  // ----------------------------------------
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_live_q;
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_live_d;
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_stk_q;
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_stk_d;
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_evt;
  logic [`NUM_REF-1:0] ref_blk_q;
  logic [`NUM_REF-1:0] ref_blk_d;

  // Live conditions; offset alarm has hysteresis between the two ranges
  for (genvar r = 0; r < `NUM_REF; r++)
  begin : g_ref
    assign ref_live_d[r][`REF_FFO] = ref_mon_i[r].freq_reject |
      (ref_live_q[r][`REF_FFO] & ~ref_mon_i[r].freq_accept);
    assign ref_live_d[r][`REF_LOS] = ref_mon_i[r].period_over;
    assign ref_live_d[r][`REF_ACT] = ref_mon_i[r].act_over;
    for (genvar a = 0; a < `REF_ALM_W; a++)
    begin : g_bit
      // Any change, either direction, counts as an event
      assign ref_evt[r][a] = (ref_live_d[r][a] ^ ref_live_q[r][a]) &
        ref_alm_en_i[r][a] & global_en_q;
      assign ref_stk_d[r][a] = set_wins(ref_stk_q[r][a], ref_evt[r][a],
        ref_clr_i[r][a]);
    end
    // Re-armed by any individual sticky still standing
    assign ref_blk_d[r] = set_wins(ref_blk_q[r], |ref_stk_q[r], ref_blk_clr_i[r]);
  end

  // Reference status registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_live_q <= '0;
      ref_stk_q <= '0;
      ref_blk_q <= '0;
    end
    else
    begin
      ref_live_q <= ref_live_d;
      ref_stk_q <= ref_stk_d;
      ref_blk_q <= ref_blk_d;
    end
  end

  // ----------------------------------------
  // Digital loop alarms (system loop is index 0)
  // ----------------------------------------
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_live_q;
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_live_d;
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_stk_q;
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_stk_d;
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] loop_evt;
  logic [`NUM_LOOP-1:0] loop_blk_q;
  logic [`NUM_LOOP-1:0] loop_blk_d;
  alarm_pkg::loop_state_t loop_state_q [`NUM_LOOP];

  // Same alarm set replicated for every loop
  for (genvar l = 0; l < `NUM_LOOP; l++)
  begin : g_loop
    assign loop_live_d[l][`LOOP_HOLD] = (loop_state_i[l] == alarm_pkg::ST_HOLDOVER);
    assign loop_live_d[l][`LOOP_LOCK] = (loop_state_i[l] == alarm_pkg::ST_LOCKED) &
      apll_locked_i;
    for (genvar a = 0; a < `LOOP_ALM_W; a++)
    begin : g_bit
      // State transitions into or out of a state raise the sticky
      assign loop_evt[l][a] = (loop_live_d[l][a] ^ loop_live_q[l][a]) &
        loop_alm_en_i[l][a] & global_en_q;
      assign loop_stk_d[l][a] = set_wins(loop_stk_q[l][a], loop_evt[l][a],
        loop_clr_i[l][a]);
    end
    assign loop_blk_d[l] = set_wins(loop_blk_q[l], |loop_stk_q[l], loop_blk_clr_i[l]);
  end

  // Loop status registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loop_live_q <= '0;
      loop_stk_q <= '0;
      loop_blk_q <= '0;
      loop_state_q <= '{default: alarm_pkg::ST_FREERUN};
    end
    else
    begin
      loop_live_q <= loop_live_d;
      loop_stk_q <= loop_stk_d;
      loop_blk_q <= loop_blk_d;
      loop_state_q <= loop_state_i;
    end
  end

  // ----------------------------------------
  // Alert aggregation
  // ----------------------------------------
  logic [`NUM_REF-1:0] ref_alert_hit;
  logic [`NUM_LOOP-1:0] loop_alert_hit;
  logic alert_any;

  // Only sticky state feeds the alert, so its cause stays readable
  for (genvar r = 0; r < `NUM_REF; r++)
  begin : g_ref_alert
    assign ref_alert_hit[r] = |(ref_stk_q[r] & ref_alert_sel_i[r]) |
      (ref_blk_q[r] & |ref_alert_sel_i[r]);
  end
  for (genvar l = 0; l < `NUM_LOOP; l++)
  begin : g_loop_alert
    assign loop_alert_hit[l] = |(loop_stk_q[l] & loop_alert_sel_i[l]) |
      (loop_blk_q[l] & |loop_alert_sel_i[l]);
  end
  assign alert_any = |ref_alert_hit | |loop_alert_hit;

  // ----------------------------------------
  // Pin selection
  // ----------------------------------------
  logic [`NUM_GPIO-1:0] pin_d;
  logic [`NUM_GPIO-1:0] pin_oe_n_d;
  logic [`NUM_GPIO-1:0] pin_is_alert;

  // Alert designation overrides the pin's individual mode
  for (genvar g = 0; g < `NUM_GPIO; g++)
  begin : g_pin
    alarm_pkg::pin_cfg_t cfg;
    logic ind;
    assign cfg = pin_cfg_i[g];
    assign pin_is_alert[g] = alert_pin_en_i & (alert_pin_idx_i == 4'(g));
    always_comb
    begin
      unique case (cfg.mode)
        alarm_pkg::PIN_OFF: ind = 1'b0;
        alarm_pkg::PIN_LOS: ind = ref_live_q[cfg.sel][`REF_LOS] &
          ref_alm_en_i[cfg.sel][`REF_LOS];
        alarm_pkg::PIN_LOL: ind = loop_stk_q[cfg.sel][`LOOP_LOCK] |
          loop_blk_q[cfg.sel];
        alarm_pkg::PIN_HOLD: ind = loop_stk_q[cfg.sel][`LOOP_HOLD] |
          loop_blk_q[cfg.sel];
      endcase
    end
    assign pin_d[g] = pin_is_alert[g] ? alert_any : ind;
    // Undriven pins stay off the line
    assign pin_oe_n_d[g] = ~(pin_is_alert[g] | (cfg.mode != alarm_pkg::PIN_OFF));
  end

  // Pin registers, idle and released after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gpio_o <= '0;
      gpio_oe_n_o <= '1;
    end
    else
    begin
      gpio_o <= pin_d;
      gpio_oe_n_o <= pin_oe_n_d;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  assign global_en_o = global_en_q;
  assign ref_live_o = ref_live_q;
  assign ref_sticky_o = ref_stk_q;
  assign loop_live_o = loop_live_q;
  assign loop_sticky_o = loop_stk_q;
  assign ref_blk_o = ref_blk_q;
  assign loop_blk_o = loop_blk_q;
  assign loop_state_o = loop_state_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_stk_on_change;
    @(posedge clk_i) disable iff (rst_i)
    (global_en_q & ref_alm_en_i[0][`REF_LOS] & (ref_mon_i[0].period_over != ref_live_q[0][`REF_LOS]))
      |=> ref_stk_q[0][`REF_LOS];
  endproperty
  a_stk_on_change: assert property (p_stk_on_change) else $error("sticky missed change");

  property p_set_wins;
    @(posedge clk_i) disable iff (rst_i)
    (ref_evt[1][`REF_ACT] & ref_clr_i[1][`REF_ACT]) |=> ref_stk_q[1][`REF_ACT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");

  property p_stk_holds;
    @(posedge clk_i) disable iff (rst_i)
    (loop_stk_q[0][`LOOP_LOCK] & ~loop_clr_i[0][`LOOP_LOCK]) |=> loop_stk_q[0][`LOOP_LOCK];
  endproperty
  a_stk_holds: assert property (p_stk_holds) else $error("sticky dropped");

  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
    (loop_clr_i[1][`LOOP_HOLD] & ~loop_evt[1][`LOOP_HOLD]) |=> ~loop_stk_q[1][`LOOP_HOLD];
  endproperty
  a_clear: assert property (p_clear) else $error("sticky not cleared");

  property p_lock_live;
    @(posedge clk_i) disable iff (rst_i)
    (loop_state_i[0] == alarm_pkg::ST_LOCKED && !apll_locked_i) |=> !loop_live_q[0][`LOOP_LOCK];
  endproperty
  a_lock_live: assert property (p_lock_live) else $error("lock live without analog lock");

  property p_hold_live;
    @(posedge clk_i) disable iff (rst_i)
    (loop_state_i[2] == alarm_pkg::ST_HOLDOVER) |=> loop_live_q[2][`LOOP_HOLD];
  endproperty
  a_hold_live: assert property (p_hold_live) else $error("holdover live missing");

  property p_no_evt_disabled;
    @(posedge clk_i) disable iff (rst_i)
    (!global_en_q && !ref_stk_q[2][`REF_FFO]) |=> !ref_stk_q[2][`REF_FFO] || $past(ref_clr_i[2][`REF_FFO]) == 1'b0 && $past(global_en_q);
  endproperty
  a_no_evt_disabled: assert property (p_no_evt_disabled) else $error("sticky set while disabled");

  property p_blk_follows;
    @(posedge clk_i) disable iff (rst_i)
    (|ref_stk_q[3]) |=> ref_blk_q[3];
  endproperty
  a_blk_follows: assert property (p_blk_follows) else $error("block sticky not set");

  property p_alert_pin;
    @(posedge clk_i) disable iff (rst_i)
    (alert_pin_en_i && alert_pin_idx_i == 4'h8) |=> gpio_o[8] == $past(alert_any) && !gpio_oe_n_o[8];
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin mismatch");

  property p_alert_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (ref_stk_q[0][`REF_LOS] & ref_alert_sel_i[0][`REF_LOS]) |-> alert_any;
  endproperty
  a_alert_sticky: assert property (p_alert_sticky) else $error("alert ignores sticky");

  // No sticky and no block sticky means the alert must be quiet
  property p_alert_none;
    @(posedge clk_i) disable iff (rst_i)
    (ref_stk_q == '0 && ref_blk_q == '0 && loop_stk_q == '0 && loop_blk_q == '0) |-> !alert_any;
  endproperty
  a_alert_none: assert property (p_alert_none) else $error("alert without sticky");

  // Checked through reset itself, so no disable here
  property p_reset_clear;
    @(posedge clk_i)
    rst_i |=> (ref_stk_q == '0) && (loop_stk_q == '0) && !global_en_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");

  property p_glob_set;
    @(posedge clk_i) disable iff (rst_i)
    global_en_set_i |=> global_en_q;
  endproperty
  a_glob_set: assert property (p_glob_set) else $error("global enable not set");

  property p_glob_clr;
    @(posedge clk_i) disable iff (rst_i)
    (global_en_clr_i && !global_en_set_i) |=> !global_en_q;
  endproperty
  a_glob_clr: assert property (p_glob_clr) else $error("global enable not cleared");

  property p_ref_en_gate;
    @(posedge clk_i) disable iff (rst_i)
    (!ref_alm_en_i[1][`REF_LOS] && !ref_stk_q[1][`REF_LOS]) |=> !ref_stk_q[1][`REF_LOS];
  endproperty
  a_ref_en_gate: assert property (p_ref_en_gate) else $error("masked alarm set sticky");

  property p_blk_clear;
    @(posedge clk_i) disable iff (rst_i)
    (loop_blk_clr_i[1] && !(|loop_stk_q[1])) |=> !loop_blk_q[1];
  endproperty
  a_blk_clear: assert property (p_blk_clear) else $error("block sticky not cleared");

  property p_los_pin;
    @(posedge clk_i) disable iff (rst_i)
    (pin_cfg_i[0].mode == alarm_pkg::PIN_LOS && pin_cfg_i[0].sel == 2'h0 &&
      ref_alm_en_i[0][`REF_LOS] && !pin_is_alert[0]) |=> gpio_o[0] == $past(ref_live_q[0][`REF_LOS]);
  endproperty
  a_los_pin: assert property (p_los_pin) else $error("loss pin not following live");

endmodule

`default_nettype wire

// >>> tb/alarm_host_model.sv
// Purpose: Host model that services alarms through the clear controls
// Assumes: Tasks are called just after a rising clock edge
// Notes:   Every control pulse lasts exactly one clock
`include "alarm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module alarm_host_model
(
  // Clock
  input wire logic clk_i,
  // Status read by the host
  input wire logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_sticky_i,
  // Controls driven by the host
  output logic en_set_o,
  output logic en_clr_o,
  output logic [`NUM_REF-1:0][`REF_ALM_W-1:0] ref_clr_o,
  output logic [`NUM_REF-1:0] ref_blk_clr_o
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial
  begin
    en_set_o = 1'b0;
    en_clr_o = 1'b0;
    ref_clr_o = '0;
    ref_blk_clr_o = '0;
  end

  // Pulse lasts to the next edge, so the design sees it once
  task automatic end_pulse;
    @(posedge clk_i);
    #1;
    en_set_o = 1'b0;
    en_clr_o = 1'b0;
    ref_clr_o = '0;
    ref_blk_clr_o = '0;
  endtask

  // Global enable on or off
  task automatic enable(input logic on);
    en_set_o = on;
    en_clr_o = !on;
    end_pulse();
  endtask

  // Raw clear pulse of chosen bits
  task automatic pulse_ref(input int idx, input logic [`REF_ALM_W-1:0] bits);
    ref_clr_o[idx] = bits;
    end_pulse();
  endtask

  // Clear exactly what was read; individual bits go first
  task automatic clear_ref(input int idx);
    pulse_ref(idx, ref_sticky_i[idx]);
  endtask

  // Block clear, only after the individual clear
  task automatic clear_blk(input int idx);
    ref_blk_clr_o[idx] = 1'b1;
    end_pulse();
  endtask
endmodule
`default_nettype wire

// >>> tb/alarm_status_aggregation_tb.sv
// Purpose: Directed test of live, sticky, block and pin alarm behaviour
// Assumes: Latencies as handed over: live and sticky one edge, pins two
// Notes:   Pin 8 is the alert; only monitor 0 feeds it
`include "alarm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module alarm_status_aggregation_tb;
  logic clk_i;
  logic rst_i;
  alarm_pkg::ref_mon_t mon [`NUM_REF];
  alarm_pkg::loop_state_t st [`NUM_LOOP];
  alarm_pkg::loop_state_t st_o [`NUM_LOOP];
  alarm_pkg::pin_cfg_t cfg [`NUM_GPIO];
  logic apll;
  logic en_set;
  logic en_clr;
  logic glob;
  logic a_en;
  logic [`NUM_REF-1:0][`REF_ALM_W-1:0] r_sel, r_clr, r_live, r_stk, r_en;
  logic [`NUM_LOOP-1:0][`LOOP_ALM_W-1:0] l_live, l_stk, l_clr;
  logic [`NUM_REF-1:0] r_bclr, r_blk;
  logic [`NUM_LOOP-1:0] l_blk, l_bclr;
  logic [`NUM_GPIO-1:0] gpio, oe_n;
  int fails;
  int n_tests;

  // ----------------------------------------
  // Design, host and clock
  // ----------------------------------------
  alarm_status_aggregation i_dut (.clk_i(clk_i), .rst_i(rst_i), .ref_mon_i(mon),
    .loop_state_i(st), .apll_locked_i(apll), .global_en_set_i(en_set),
    .global_en_clr_i(en_clr), .ref_alm_en_i(r_en), .loop_alm_en_i('1),
    .ref_alert_sel_i(r_sel), .loop_alert_sel_i('0), .pin_cfg_i(cfg),
    .alert_pin_en_i(a_en), .alert_pin_idx_i(4'h8), .ref_clr_i(r_clr), .loop_clr_i(l_clr),
    .ref_blk_clr_i(r_bclr), .loop_blk_clr_i(l_bclr), .global_en_o(glob), .ref_live_o(r_live),
    .ref_sticky_o(r_stk), .loop_live_o(l_live), .loop_sticky_o(l_stk), .ref_blk_o(r_blk),
    .loop_blk_o(l_blk), .loop_state_o(st_o), .gpio_o(gpio), .gpio_oe_n_o(oe_n));

  alarm_host_model i_host (.clk_i(clk_i), .ref_sticky_i(r_stk), .en_set_o(en_set),
    .en_clr_o(en_clr), .ref_clr_o(r_clr), .ref_blk_clr_o(r_bclr));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = !clk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Inputs move 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #100000;
    fails++;
    $display("MISMATCH %0t timeout", $time);
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    fails = 0;
    n_tests = 0;
    rst_i = 1'b1;
    apll = 1'b0;
    a_en = 1'b0;
    r_sel = '0;
    r_sel[0] = 3'h7;
    r_en = '1;
    l_clr = '0;
    l_bclr = '0;
    foreach (mon[i]) mon[i] = '0;
    foreach (st[i]) st[i] = alarm_pkg::ST_FREERUN;
    foreach (cfg[i]) cfg[i] = '{alarm_pkg::PIN_OFF, 2'h0};
    cfg[0] = '{alarm_pkg::PIN_LOS, 2'h0};
    cfg[1] = '{alarm_pkg::PIN_HOLD, 2'h1};
    cfg[2] = '{alarm_pkg::PIN_LOL, 2'h0};
    cfg[3] = '{alarm_pkg::PIN_LOS, 2'h1};
    step(10);
    chk(r_stk, 16'h0, "sticky after reset");
    chk(glob, 16'h0, "enable after reset");
    chk(oe_n, 16'h1ff, "pins after reset");
    chk({l_stk, l_blk}, 16'h0, "loop stickies after reset");
    chk(gpio, 16'h0, "pin levels after reset");
    rst_i = 1'b0;
    a_en = 1'b1;
    // Disabled: live tracks, sticky must not set
    mon[0].period_over = 1'b1;
    step(1);
    chk(r_live[0], 16'h2, "live loss");
    chk(r_stk[0], 16'h0, "sticky while disabled");
    mon[0].period_over = 1'b0;
    step(1);
    i_host.enable(1'b1);
    chk(glob, 16'h1, "global enable");
    // Two alarms on one monitor at once
    mon[0].freq_reject = 1'b1;
    mon[0].period_over = 1'b1;
    step(2);
    chk(r_live[0], 16'h3, "live pair");
    chk(r_stk[0], 16'h3, "sticky pair");
    chk(r_blk[0], 16'h1, "block set");
    chk(gpio[0], 16'h1, "loss pin up");
    chk({oe_n[8], gpio[8]}, 16'h1, "alert up");
    mon[0] = '0;
    step(2);
    chk(r_live[0], 16'h1, "offset held");
    chk(gpio[0], 16'h0, "loss pin follows live");
    chk(r_stk[0], 16'h3, "sticky held");
    chk(gpio[8], 16'h1, "alert from sticky");
    mon[0].freq_accept = 1'b1;
    step(1);
    chk(r_live[0], 16'h0, "offset accepted");
    i_host.clear_ref(0);
    chk(r_stk[0], 16'h0, "combined clear");
    step(2);
    chk(gpio[8], 16'h1, "alert held by block");
    i_host.clear_blk(0);
    chk(r_blk[0], 16'h0, "block cleared");
    step(1);
    chk(gpio[8], 16'h0, "alert released");
    // Set and clear land on the same edge
    mon[2].act_over = 1'b1;
    i_host.pulse_ref(2, 3'h4);
    chk(r_live[2], 16'h4, "activity live");
    chk(r_stk[2], 16'h4, "set beats clear");
    // Holdover on a channel loop
    st[1] = alarm_pkg::ST_HOLDOVER;
    step(2);
    chk(l_live[1], 16'h1, "holdover live");
    chk(l_stk[1], 16'h1, "holdover sticky");
    chk(st_o[1], alarm_pkg::ST_HOLDOVER, "state readable");
    chk(gpio[1], 16'h1, "holdover pin");
    st[1] = alarm_pkg::ST_ACQUIRE;
    step(1);
    chk(l_live[1], 16'h0, "holdover left");
    // Lock on the system loop needs both loops
    st[0] = alarm_pkg::ST_LOCKED;
    apll = 1'b1;
    step(2);
    chk(l_live[0], 16'h2, "locked live");
    chk(gpio[2], 16'h1, "lock pin");
    apll = 1'b0;
    step(1);
    chk(l_live[0], 16'h0, "analog unlock");
    step(1);
    chk(gpio[2], 16'h1, "lock pin latched");
    chk(gpio[8], 16'h0, "unselected kept off alert");
    // Masked alarm: live tracks, sticky and pin stay quiet
    r_en[1] = 3'h5;
    mon[1].period_over = 1'b1;
    step(2);
    chk(r_live[1], 16'h2, "live tracks while masked");
    chk(r_stk[1], 16'h0, "masked alarm kept off sticky");
    chk(gpio[3], 16'h0, "masked loss pin");
    mon[1].period_over = 1'b0;
    step(1);
    r_en[1] = 3'h7;
    // Channel loop clears: individual first, then block
    l_clr[1] = 2'h1;
    step(1);
    l_clr = '0;
    chk(l_stk[1], 16'h0, "loop sticky cleared");
    l_bclr[1] = 1'b1;
    step(1);
    l_bclr = '0;
    chk(l_blk[1], 16'h0, "loop block cleared");
    chk(gpio[1], 16'h1, "holdover pin held by block");
    step(1);
    chk(gpio[1], 16'h0, "holdover pin released");
    i_host.enable(1'b0);
    chk(glob, 16'h0, "global disable");
    final_report();
  end
endmodule
`default_nettype wire
